// >>> tb/mcu_alu_exec_tb.sv
`timescale 1ns/1ns
module mcu_alu_exec_tb;

	// ------------------------------------------------------------
	// Signals and model state
	// ------------------------------------------------------------
	localparam int unsigned PRESC = 64;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, wake;
	logic awready, wready, bvalid, arready, rvalid, sleeping, osc_run;
	logic [7:0] awaddr, araddr, port_a_direction, port_b_direction, port_c_direction;
	logic [31:0] wdata, rdata, rd_q;
	logic [3:0] wstrb, op;
	logic [1:0] bresp, rresp, rr_q;
	logic [7:0] acc_m, fv, k, res, fa, da, db, dd, a;
	logic c_m, dc_m, z_m, dest, bor;
	int miscompares, check_count, seed, t, v;

	mcu_alu_exec #(.PRESCALE(PRESC), .WDT_W(8)) uut (.aclk(aclk), .aresetn(aresetn),
		.awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
		.wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
		.arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
		.rdata(rdata), .rresp(rresp), .wake(wake), .sleeping(sleeping), .osc_run(osc_run),
		.port_a_direction(port_a_direction), .port_b_direction(port_b_direction),
		.port_c_direction(port_c_direction));

	initial
	begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end

	// ------------------------------------------------------------
	// Bus and compare tasks
	// ------------------------------------------------------------
	task chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task results;
		if (miscompares == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task wr(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge aclk);
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		awaddr <= ad;
		wdata <= d;
		wstrb <= 4'hF;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			n++;
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
		end
		while (bvalid !== 1'b1 && n < 100);
		bready <= 1'b0;
		if (n >= 100)
			miscompares++;
		chk({30'h0, bresp}, {30'h0, er});
	endtask

	task rd(input logic [7:0] ad);
		int n;
		n = 0;
		@(posedge aclk);
		arvalid <= 1'b1;
		araddr <= ad;
		rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			n++;
			if (arvalid && arready)
				arvalid <= 1'b0;
		end
		while (rvalid !== 1'b1 && n < 100);
		rd_q = rdata;
		rr_q = rresp;
		rready <= 1'b0;
		if (n >= 100)
			miscompares++;
	endtask

	task rdc(input logic [7:0] ad, input logic [31:0] exp);
		rd(ad);
		chk(rd_q, exp);
		chk({30'h0, rr_q}, {30'h0, alu_pkg::RESP_OKAY});
	endtask

	task chk_dirs;
		chk({8'h00, port_a_direction, port_b_direction, port_c_direction}, {8'h00, da, db, dd});
	endtask

	// ------------------------------------------------------------
	// Watchdog, sized well beyond the expected run
	// ------------------------------------------------------------
	initial
	begin
		#3000000;
		miscompares++;
		results();
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, wake} = '0;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		wstrb = 4'h0;
		miscompares = 0;
		check_count = 0;
		seed = 32'hB575;
		{da, db, dd} = {3{alu_pkg::DIR_RST}};
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		rdc(alu_pkg::ADDR_ACC, 32'h0);
		rdc(alu_pkg::ADDR_STATUS, 32'h18);
		chk_dirs();
		for (int i = 0; i < 90; i++)
		begin
			op = 4'($random(seed) & 7);
			acc_m = 8'($random(seed));
			{z_m, dc_m, c_m} = 3'($random(seed));
			fa = 8'($random(seed) & 8'h7F);
			fv = 8'($random(seed));
			k = 8'($random(seed));
			dest = 1'($random(seed));
			// Equal operands give zero results and the carry boundary
			if (($random(seed) & 3) == 0)
			begin
				fv = acc_m;
				k = acc_m;
			end
			if (op inside {4'd2, 4'd3, 4'd4, 4'd6})
				k = {1'($random(seed)), fa[6:0]};
			v = $random(seed) & 7;
			if (op == 4'd7)
				k = 8'(4 + v % 5);
			wr(alu_pkg::ADDR_ACC, {24'h0, acc_m}, alu_pkg::RESP_OKAY);
			wr(alu_pkg::ADDR_STATUS, {24'h0, 3'($random(seed)), z_m, dc_m, c_m}, alu_pkg::RESP_OKAY);
			wr(alu_pkg::ADDR_FILE_ADDR, {24'h0, fa}, alu_pkg::RESP_OKAY);
			wr(alu_pkg::ADDR_FILE_DATA, {24'h0, fv}, alu_pkg::RESP_OKAY);
			wr(alu_pkg::ADDR_INSTR, {8'h00, k, 7'h00, dest, 4'h0, op}, alu_pkg::RESP_OKAY);
			res = 8'h00;
			if (op inside {4'd1, 4'd2, 4'd3})
			begin
				a = (op == 4'd1) ? k : fv;
				bor = (op == 4'd3) ? ~c_m : 1'b0;
				t = int'(a) - int'(acc_m) - int'(bor);
				res = 8'(t);
				c_m = (t >= 0);
				dc_m = (int'(a[3:0]) - int'(acc_m[3:0]) - int'(bor)) >= 0;
				z_m = (res == 8'h00);
			end
			if (op == 4'd4)
				res = {fv[3:0], fv[7:4]};
			if (op == 4'd5)
				res = acc_m ^ k;
			if (op == 4'd6)
				res = acc_m ^ fv;
			if (op inside {4'd5, 4'd6})
				z_m = (res == 8'h00);
			if (op inside {4'd1, 4'd5})
				acc_m = res;
			else if (op inside {4'd2, 4'd3, 4'd4, 4'd6})
			begin
				if (dest)
					fv = res;
				else
					acc_m = res;
			end
			if (op == 4'd7)
			begin
				da = (k == 8'h05) ? acc_m : da;
				db = (k == 8'h06) ? acc_m : db;
				dd = (k == 8'h07) ? acc_m : dd;
			end
			rdc(alu_pkg::ADDR_ACC, {24'h0, acc_m});
			rdc(alu_pkg::ADDR_STATUS, {26'h0, 3'b011, z_m, dc_m, c_m});
			rdc(alu_pkg::ADDR_FILE_DATA, {24'h0, fv});
			chk_dirs();
		end
		// Refused accesses leave state alone
		wr(alu_pkg::ADDR_DIR_A, 32'h0, alu_pkg::RESP_SLVERR);
		wr(8'h3C, 32'h0, alu_pkg::RESP_SLVERR);
		rd(8'h3C);
		chk({rd_q[31:2], rr_q}, {30'h0, alu_pkg::RESP_SLVERR});
		rdc(alu_pkg::ADDR_INSTR, 32'h0);
		chk_dirs();
		// Let the watchdog run so that its clearing is visible
		repeat (PRESC * 3) @(posedge aclk);
		rd(alu_pkg::ADDR_WDT);
		chk({31'h0, rd_q[7:0] != 8'h00}, 32'h1);
		wr(alu_pkg::ADDR_INSTR, {28'h0, 4'd8}, alu_pkg::RESP_OKAY);
		chk({30'h0, sleeping, osc_run}, 32'h2);
		rdc(alu_pkg::ADDR_WDT, {24'h0, alu_pkg::WDT_CLEAR});
		rdc(alu_pkg::ADDR_STATUS, {26'h0, 3'b110, z_m, dc_m, c_m});
		wr(alu_pkg::ADDR_INSTR, {8'h00, 8'hFF, 12'h000, 4'd5}, alu_pkg::RESP_SLVERR);
		rdc(alu_pkg::ADDR_ACC, {24'h0, acc_m});
		@(posedge aclk);
		wake <= 1'b1;
		@(posedge aclk);
		wake <= 1'b0;
		@(posedge aclk);
		chk({30'h0, sleeping, osc_run}, 32'h1);
		rdc(alu_pkg::ADDR_STATUS, {26'h0, 3'b010, z_m, dc_m, c_m});
		results();
	end

endmodule

// >>> verilog/alu_exec_unit.sv
`timescale 1ns/1ns
module alu_exec_unit
(
	// Instruction and operands
	input wire alu_pkg::instr_s instr,
	input wire logic [7:0] acc,
	input wire logic [7:0] file_val,
	input wire logic carry,
	// Outcome
	output alu_pkg::alu_out_s res
);

	logic [7:0] minuend;
	logic cin;
	logic [8:0] sum9;
	logic [4:0] sum5;
	logic [7:0] value;

	// Subtraction as minuend + ~acc + cin; carry out set means no borrow
	assign minuend = (instr.op == alu_pkg::op_subtract_from_literal) ? instr.operand : file_val;
	assign cin = (instr.op == alu_pkg::op_subtract_with_borrow) ? carry : 1'b1; // [RULE5]
	assign sum9 = {1'b0, minuend} + {1'b0, ~acc} + {8'h00, cin}; // [RULE1] [RULE3]
	assign sum5 = {1'b0, minuend[3:0]} + {1'b0, ~acc[3:0]} + {4'h0, cin}; // [RULE2] [RULE4]

	always_comb
	begin
		value = 8'h00;
		res = '0;
		unique case (instr.op)
			alu_pkg::op_subtract_from_literal:
			begin
				value = sum9[7:0];
				res.upd_cdc = 1'b1;
				res.upd_z = 1'b1;
				res.wr_acc = 1'b1; // [RULE1]
			end
			alu_pkg::op_subtract_from_register, alu_pkg::op_subtract_with_borrow:
			begin
				value = sum9[7:0];
				res.upd_cdc = 1'b1;
				res.upd_z = 1'b1;
				res.wr_acc = ~instr.dest; // [RULE3] [RULE5]
				res.wr_file = instr.dest;
			end
			alu_pkg::op_nibble_swap:
			begin
				value = {file_val[3:0], file_val[7:4]}; // [RULE6]
				res.wr_acc = ~instr.dest;
				res.wr_file = instr.dest;
			end
			alu_pkg::op_xor_with_literal:
			begin
				value = acc ^ instr.operand; // [RULE7]
				res.upd_z = 1'b1;
				res.wr_acc = 1'b1;
			end
			alu_pkg::op_xor_with_register:
			begin
				value = acc ^ file_val; // [RULE8]
				res.upd_z = 1'b1;
				res.wr_acc = ~instr.dest;
				res.wr_file = instr.dest;
			end
			alu_pkg::op_direction_load:
			begin
				value = acc; // [RULE9]
				res.wr_dir = 1'b1;
			end
			alu_pkg::op_sleep:
			begin
				res.sleep = 1'b1; // [RULE10]
			end
			default:
			begin
				value = 8'h00;
			end
		endcase
		res.result = value;
		res.c = sum9[8];
		res.dc = sum5[4];
		res.z = (value == 8'h00); // [RULE13]
	end

endmodule

// >>> verilog/alu_pkg.sv
package alu_pkg;

	// ----------------------------------------------------------------
	// Register map, byte addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_INSTR = 8'h00;
	localparam logic [7:0] ADDR_ACC = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_DIR_A = 8'h0C;
	localparam logic [7:0] ADDR_DIR_B = 8'h10;
	localparam logic [7:0] ADDR_DIR_C = 8'h14;
	localparam logic [7:0] ADDR_WDT = 8'h18;
	localparam logic [7:0] ADDR_FILE_ADDR = 8'h1C;
	localparam logic [7:0] ADDR_FILE_DATA = 8'h20;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int unsigned INSTR_OP_LSB = 0;
	localparam int unsigned INSTR_DEST_BIT = 8;
	localparam int unsigned INSTR_OPND_LSB = 16;
	localparam int unsigned ST_C = 0;
	localparam int unsigned ST_DC = 1;
	localparam int unsigned ST_Z = 2;
	localparam int unsigned ST_PD = 3;
	localparam int unsigned ST_TO = 4;
	localparam int unsigned ST_SLEEP = 5;

	// ----------------------------------------------------------------
	// Reset values and fixed codes
	// ----------------------------------------------------------------
	localparam logic [7:0] ACC_RST = 8'h00;
	localparam logic [7:0] DIR_RST = 8'hFF;
	localparam logic [6:0] FILE_ADDR_RST = 7'h00;
	localparam logic [7:0] WDT_CLEAR = 8'h00;
	localparam logic [7:0] DIR_FIRST = 8'h05;
	localparam logic [7:0] DIR_LAST = 8'h07;
	localparam int unsigned DIR_COUNT = 3;
	localparam int unsigned FILE_DEPTH = 128;
	localparam int unsigned PRESCALE_DIV = 16;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		op_none,
		op_subtract_from_literal,
		op_subtract_from_register,
		op_subtract_with_borrow,
		op_nibble_swap,
		op_xor_with_literal,
		op_xor_with_register,
		op_direction_load,
		op_sleep
	} alu_op_e;

	typedef struct packed {
		alu_op_e op;
		logic dest;
		logic [7:0] operand;
	} instr_s;

	typedef struct packed {
		logic [7:0] result;
		logic c;
		logic dc;
		logic z;
		logic upd_cdc;
		logic upd_z;
		logic wr_acc;
		logic wr_file;
		logic wr_dir;
		logic sleep;
	} alu_out_s;

endpackage

// >>> verilog/mcu_alu_exec.sv
// Chosen here: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ns
// Overview of operation
// (RULE1) Literal minus accumulator written to accumulator
// (RULE2) Carry/digit carry set when accumulator not above
// (RULE3) Register minus accumulator, destination bit routes
// (RULE4) Carry/digit carry compare register with accumulator
// (RULE5) Register minus accumulator minus inverted carry
// (RULE6) Swap nibbles of register, flags unchanged
// (RULE7) Accumulator xor literal, only zero flag
// (RULE8) Accumulator xor register, routed, zero flag
// (RULE9) Operand five to seven loads port direction
// (RULE10) Sleep clears powerdown flag, sets timeout flag
// (RULE11) Sleep clears watchdog counter and prescaler
// (RULE12) Sleep halts core, oscillator stopped
// (RULE13) Zero flag set when result is zero
module mcu_alu_exec
#(
	parameter int unsigned PRESCALE = alu_pkg::PRESCALE_DIV,
	parameter int unsigned WDT_W = 8
)
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address
	input wire logic awvalid,
	output logic awready,
	input wire logic [7:0] awaddr,
	// AXI4-Lite write data
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	// AXI4-Lite write response
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// AXI4-Lite read address
	input wire logic arvalid,
	output logic arready,
	input wire logic [7:0] araddr,
	// AXI4-Lite read data
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	// Core side
	input wire logic wake,
	output logic sleeping,
	output logic osc_run,
	output logic [7:0] port_a_direction,
	output logic [7:0] port_b_direction,
	output logic [7:0] port_c_direction
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic aw_have_q;
	logic [7:0] awaddr_q;
	logic w_have_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;
	logic [7:0] acc_q;
	logic carry_flag_q;
	logic digit_carry_flag_q;
	logic zero_flag_q;
	logic timeout_flag_q;
	logic powerdown_flag_q;
	logic [6:0] file_addr_q;
	logic [7:0] file_mem [alu_pkg::FILE_DEPTH];
	logic [7:0] dir_q [alu_pkg::DIR_COUNT];

	// ----------------------------------------------------------------
	// Write channel decode
	// ----------------------------------------------------------------
	logic wr_fire;
	logic wr_lane0;
	logic wr_instr;
	logic wr_acc;
	logic wr_status;
	logic wr_faddr;
	logic wr_fdata;
	logic wr_ok;
	logic exec;
	alu_pkg::instr_s instr;
	alu_pkg::alu_out_s alu;
	logic [7:0] file_val;
	logic dir_hit;
	logic [7:0] dir_index;
	logic [WDT_W-1:0] wdt_count;

	assign awready = ~aw_have_q;
	assign wready = ~w_have_q;
	assign wr_fire = aw_have_q & w_have_q & ~bvalid_q;
	assign wr_lane0 = wr_fire & wstrb_q[0];
	assign wr_instr = awaddr_q == alu_pkg::ADDR_INSTR;
	assign wr_acc = wr_lane0 & (awaddr_q == alu_pkg::ADDR_ACC);
	assign wr_status = wr_lane0 & (awaddr_q == alu_pkg::ADDR_STATUS);
	assign wr_faddr = wr_lane0 & (awaddr_q == alu_pkg::ADDR_FILE_ADDR);
	assign wr_fdata = wr_lane0 & (awaddr_q == alu_pkg::ADDR_FILE_DATA);
	// A halted core refuses instructions; the write answers with an error
	assign wr_ok = wr_instr ? ~sleeping : (awaddr_q == alu_pkg::ADDR_ACC) | (awaddr_q == alu_pkg::ADDR_STATUS)
		| (awaddr_q == alu_pkg::ADDR_FILE_ADDR) | (awaddr_q == alu_pkg::ADDR_FILE_DATA);
	assign exec = wr_lane0 & wr_instr & ~sleeping; // [RULE12]

	assign instr.op = alu_pkg::alu_op_e'(wdata_q[alu_pkg::INSTR_OP_LSB +: 4]);
	assign instr.dest = wdata_q[alu_pkg::INSTR_DEST_BIT];
	assign instr.operand = wdata_q[alu_pkg::INSTR_OPND_LSB +: 8];
	// Register addresses span 0 to 127, the top operand bit is ignored
	assign file_val = file_mem[instr.operand[6:0]];
	assign dir_hit = (instr.operand >= alu_pkg::DIR_FIRST) && (instr.operand <= alu_pkg::DIR_LAST); // [RULE9]
	assign dir_index = instr.operand - alu_pkg::DIR_FIRST;

	alu_exec_unit u_alu
	(
		.instr(instr),
		.acc(acc_q),
		.file_val(file_val),
		.carry(carry_flag_q),
		.res(alu)
	);

	sleep_watchdog #(.PRESCALE(PRESCALE), .WDT_W(WDT_W)) u_sleep
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.sleep_req(exec & alu.sleep),
		.wake(wake),
		.sleeping(sleeping),
		.osc_run(osc_run),
		.wdt_count(wdt_count)
	);

	// ----------------------------------------------------------------
	// Write channel
	// ----------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_have_q <= 1'b0;
			awaddr_q <= 8'h00;
		end
		else if (awvalid && !aw_have_q)
		begin
			aw_have_q <= 1'b1;
			awaddr_q <= awaddr;
		end
		else if (wr_fire)
			aw_have_q <= 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			w_have_q <= 1'b0;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
		end
		else if (wvalid && !w_have_q)
		begin
			w_have_q <= 1'b1;
			wdata_q <= wdata;
			wstrb_q <= wstrb;
		end
		else if (wr_fire)
			w_have_q <= 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid_q <= 1'b0;
			bresp_q <= alu_pkg::RESP_OKAY;
		end
		else if (wr_fire)
		begin
			bvalid_q <= 1'b1;
			bresp_q <= wr_ok ? alu_pkg::RESP_OKAY : alu_pkg::RESP_SLVERR;
		end
		else if (bready)
			bvalid_q <= 1'b0;
	end

	assign bvalid = bvalid_q;
	assign bresp = bresp_q;

	// ----------------------------------------------------------------
	// Datapath registers
	// ----------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			acc_q <= alu_pkg::ACC_RST;
		else if (exec && alu.wr_acc)
			acc_q <= alu.result; // [RULE1] [RULE3] [RULE8]
		else if (wr_acc)
			acc_q <= wdata_q[7:0];
	end

	always_ff @(posedge aclk)
	begin
		if (exec && alu.wr_file)
			file_mem[instr.operand[6:0]] <= alu.result; // [RULE3] [RULE6] [RULE8]
		else if (wr_fdata)
			file_mem[file_addr_q] <= wdata_q[7:0];
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			file_addr_q <= alu_pkg::FILE_ADDR_RST;
		else if (wr_faddr)
			file_addr_q <= wdata_q[6:0];
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			carry_flag_q <= 1'b0;
			digit_carry_flag_q <= 1'b0;
			zero_flag_q <= 1'b0;
		end
		else if (exec)
		begin
			if (alu.upd_cdc)
			begin
				carry_flag_q <= alu.c; // [RULE2] [RULE4] [RULE5]
				digit_carry_flag_q <= alu.dc;
			end
			if (alu.upd_z)
				zero_flag_q <= alu.z; // [RULE13]
		end
		else if (wr_status)
		begin
			carry_flag_q <= wdata_q[alu_pkg::ST_C];
			digit_carry_flag_q <= wdata_q[alu_pkg::ST_DC];
			zero_flag_q <= wdata_q[alu_pkg::ST_Z];
		end
	end

	// Both flags read 1 after power-up; only sleep moves them here
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			timeout_flag_q <= 1'b1;
			powerdown_flag_q <= 1'b1;
		end
		else if (exec && alu.sleep)
		begin
			timeout_flag_q <= 1'b1; // [RULE10]
			powerdown_flag_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Port direction registers
	// ----------------------------------------------------------------
	generate
		for (genvar i = 0; i < alu_pkg::DIR_COUNT; i++)
		begin : g_dir
			always_ff @(posedge aclk)
			begin
				if (!aresetn)
					dir_q[i] <= alu_pkg::DIR_RST;
				else if (exec && alu.wr_dir && dir_hit && (dir_index == 8'(i)))
					dir_q[i] <= alu.result; // [RULE9]
			end
		end
	endgenerate

	assign port_a_direction = dir_q[0];
	assign port_b_direction = dir_q[1];
	assign port_c_direction = dir_q[2];

	// ----------------------------------------------------------------
	// Read channel
	// ----------------------------------------------------------------
	logic [31:0] rd_word;
	logic rd_ok;
	logic [7:0] status_word;

	assign status_word = {2'b00, sleeping, timeout_flag_q, powerdown_flag_q, zero_flag_q, digit_carry_flag_q,
		carry_flag_q};
	assign arready = ~rvalid_q;

	always_comb
	begin
		rd_word = 32'h0000_0000;
		rd_ok = 1'b1;
		case (araddr)
			alu_pkg::ADDR_INSTR: rd_word = 32'h0000_0000;
			alu_pkg::ADDR_ACC: rd_word = {24'h00_0000, acc_q};
			alu_pkg::ADDR_STATUS: rd_word = {24'h00_0000, status_word};
			alu_pkg::ADDR_DIR_A: rd_word = {24'h00_0000, dir_q[0]};
			alu_pkg::ADDR_DIR_B: rd_word = {24'h00_0000, dir_q[1]};
			alu_pkg::ADDR_DIR_C: rd_word = {24'h00_0000, dir_q[2]};
			alu_pkg::ADDR_WDT: rd_word = 32'(wdt_count);
			alu_pkg::ADDR_FILE_ADDR: rd_word = {25'h000_0000, file_addr_q};
			alu_pkg::ADDR_FILE_DATA: rd_word = {24'h00_0000, file_mem[file_addr_q]};
			default: rd_ok = 1'b0;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= alu_pkg::RESP_OKAY;
		end
		else if (arvalid && !rvalid_q)
		begin
			rvalid_q <= 1'b1;
			rdata_q <= rd_word;
			rresp_q <= rd_ok ? alu_pkg::RESP_OKAY : alu_pkg::RESP_SLVERR;
		end
		else if (rready)
			rvalid_q <= 1'b0;
	end

	assign rvalid = rvalid_q;
	assign rdata = rdata_q;
	assign rresp = rresp_q;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	sequence s_exec(alu_pkg::alu_op_e o);
		exec && instr.op == o;
	endsequence

	a_sub_lit_value: assert property (s_exec(alu_pkg::op_subtract_from_literal) |=> // [RULE1]
		acc_q == 8'($past(instr.operand) - $past(acc_q)))
		else $error("literal subtract result wrong");

	a_sub_lit_carry: assert property (s_exec(alu_pkg::op_subtract_from_literal) |=> // [RULE2]
		carry_flag_q == ($past(acc_q) <= $past(instr.operand))
		&& digit_carry_flag_q == ($past(acc_q[3:0]) <= $past(instr.operand[3:0])))
		else $error("literal subtract carry wrong");

	a_sub_reg_route: assert property (s_exec(alu_pkg::op_subtract_from_register) && !instr.dest |=> // [RULE3] [RULE4]
		acc_q == 8'($past(file_val) - $past(acc_q)) && carry_flag_q == ($past(acc_q) <= $past(file_val)))
		else $error("register subtract wrong");

	a_borrow_value: assert property (s_exec(alu_pkg::op_subtract_with_borrow) && !instr.dest |=> // [RULE5]
		acc_q == 8'($past(file_val) - $past(acc_q) - {7'h00, ~$past(carry_flag_q)}))
		else $error("borrow subtract wrong");

	a_swap_flags: assert property (s_exec(alu_pkg::op_nibble_swap) && !instr.dest |=> // [RULE6]
		acc_q == {$past(file_val[3:0]), $past(file_val[7:4])} && $stable(carry_flag_q) && $stable(zero_flag_q))
		else $error("nibble swap wrong");

	a_xor_zero: assert property (s_exec(alu_pkg::op_xor_with_literal) |=> // [RULE7] [RULE13]
		zero_flag_q == (acc_q == 8'h00) && $stable(carry_flag_q) && $stable(digit_carry_flag_q))
		else $error("xor zero flag wrong");

	a_xor_reg_file: assert property (s_exec(alu_pkg::op_xor_with_register) && instr.dest |=> // [RULE8]
		$stable(acc_q) && $stable(carry_flag_q))
		else $error("xor to register touched accumulator");

	a_dir_load: assert property (s_exec(alu_pkg::op_direction_load) && instr.operand == alu_pkg::DIR_FIRST |=> // [RULE9]
		port_a_direction == $past(acc_q) && $stable(port_b_direction))
		else $error("direction load wrong");

	a_sleep_flags: assert property (s_exec(alu_pkg::op_sleep) |=> // [RULE10] [RULE12]
		timeout_flag_q && !powerdown_flag_q && sleeping && !osc_run)
		else $error("sleep state wrong");

	a_sleep_holds: assert property (sleeping && !wake |=> sleeping && !osc_run) // [RULE12]
		else $error("sleep left without wake");

endmodule

// >>> verilog/sleep_watchdog.sv
`timescale 1ns/1ns
module sleep_watchdog
#(
	parameter int unsigned PRESCALE = alu_pkg::PRESCALE_DIV,
	parameter int unsigned WDT_W = 8
)
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Control
	input wire logic sleep_req,
	input wire logic wake,
	// State
	output logic sleeping,
	output logic osc_run,
	output logic [WDT_W-1:0] wdt_count
);

	logic [15:0] presc_q;
	logic tick;
	logic sleeping_q;
	logic osc_run_q;
	logic [WDT_W-1:0] wdt_q;

	assign tick = (presc_q == 16'(PRESCALE - 1));

	// Prescaler and counter restart together so the first timeout is full length
	always_ff @(posedge aclk)
	begin
		if (!aresetn || sleep_req)
			presc_q <= 16'h0000; // [RULE11]
		else
			presc_q <= tick ? 16'h0000 : presc_q + 16'h0001;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn || sleep_req)
			wdt_q <= WDT_W'(alu_pkg::WDT_CLEAR); // [RULE11]
		else if (tick)
			wdt_q <= wdt_q + WDT_W'(1);
	end

	// A sleep request in the same cycle as a wake still sleeps
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sleeping_q <= 1'b0;
			osc_run_q <= 1'b1;
		end
		else if (sleep_req)
		begin
			sleeping_q <= 1'b1; // [RULE12]
			osc_run_q <= 1'b0;
		end
		else if (wake)
		begin
			sleeping_q <= 1'b0;
			osc_run_q <= 1'b1;
		end
	end

	assign sleeping = sleeping_q;
	assign osc_run = osc_run_q;
	assign wdt_count = wdt_q;

	a_wdt_cleared: assert property (@(posedge aclk) disable iff (!aresetn)
		sleep_req |=> (wdt_q == '0) && (presc_q == 16'h0000)) // [RULE11]
		else $error("watchdog not cleared by sleep");

endmodule
